// file: design/cbmu_regs.vh
// operation codes and flag reset values for the bit manipulation unit
// assumes inclusion by the single design file; definitions only
`ifndef CBMU_REGS_VH
`define CBMU_REGS_VH
// operation codes on op_code
`define CBMU_OP_SET_BIT 4'h0
`define CBMU_OP_CLEAR_BIT 4'h1
`define CBMU_OP_INVERT_BIT 4'h2
`define CBMU_OP_TEST_BIT 4'h3
`define CBMU_OP_AND_CARRY 4'h4
`define CBMU_OP_AND_CARRY_INVERTED 4'h5
`define CBMU_OP_OR_CARRY 4'h6
`define CBMU_OP_OR_CARRY_INVERTED 4'h7
`define CBMU_OP_XOR_CARRY 4'h8
`define CBMU_OP_XOR_CARRY_INVERTED 4'h9
`define CBMU_OP_LOAD_TO_CARRY 4'hA
`define CBMU_OP_LOAD_INVERTED_TO_CARRY 4'hB
`define CBMU_OP_STORE_CARRY 4'hC
`define CBMU_OP_STORE_INVERTED_CARRY 4'hD
// reset values
`define CBMU_CARRY_RST 1'h0
`define CBMU_ZERO_RST 1'h0
`endif

// file: design/cbmu_bit_unit.v
// bit manipulation execution unit: set/clear/invert/test/carry ops on a byte
// assumes a sequencer gives one-cycle op_start and a byte bus answering rdy
// What this block does
// RQ1: bit number from immediate or register low three
// RQ2: set forces selected bit to one
// RQ3: clear forces selected bit to zero
// RQ4: invert complements selected bit
// RQ5: test loads zero flag with inverted bit
// RQ6: and replaces carry with carry and bit
// RQ7: inverted and uses complement of bit
// RQ8: or replaces carry with carry or bit
// RQ9: inverted or uses complement of bit
// RQ10: xor replaces carry with carry xor bit
// RQ11: inverted xor uses complement of bit
// RQ12: inverted variants take immediate bit number only
// RQ13: load copies bit into carry
// RQ14: inverted load copies complement into carry
// RQ15: store writes carry into selected bit
// RQ16: inverted store writes complemented carry into bit
// RQ17: modifying ops are whole byte read-modify-write
// RQ18: read, alter one bit, write same address
// RQ19: write-only register reads back all ones, modified
// RQ20: test, combine, load ops never write back
`timescale 1ns/100ps
`include "cbmu_regs.vh"
module cbmu_bit_unit #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // operation request
  input wire op_start,
  input wire [3:0] op_code,
  input wire op_use_reg_bitno,
  input wire [2:0] op_imm_bitno,
  input wire [7:0] op_reg_bitno,
  input wire op_mem,
  input wire [ADDR_W-1:0] op_addr,
  input wire [7:0] op_reg_data,
  output wire op_busy,
  output reg op_done,
  // register file write back
  output reg reg_we,
  output reg [7:0] reg_wdata,
  // byte memory bus
  output reg bus_rd,
  output reg bus_wr,
  output reg [ADDR_W-1:0] bus_addr,
  output reg [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire bus_rdy,
  // condition flags
  output reg carry_flag,
  output reg zero_flag
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg [1:0] state_r;
  reg [3:0] code_r;
  reg [2:0] bitno_r;
  reg [7:0] mask;
  reg [2:0] sel_bitno;
  reg is_inverted;
  reg is_modify;
  reg [7:0] mod_byte;
  reg [7:0] operand;
  reg bit_val;

  // inverted variants ignore the register source even if requested
  always @* begin
    is_inverted = (op_code == `CBMU_OP_AND_CARRY_INVERTED) ||
      (op_code == `CBMU_OP_OR_CARRY_INVERTED) ||
      (op_code == `CBMU_OP_XOR_CARRY_INVERTED) ||
      (op_code == `CBMU_OP_LOAD_INVERTED_TO_CARRY) ||
      (op_code == `CBMU_OP_STORE_INVERTED_CARRY);
    if (op_use_reg_bitno && !is_inverted) begin
      sel_bitno = op_reg_bitno[2:0]; // [RQ1]
    end else begin
      sel_bitno = op_imm_bitno; // [RQ1] [RQ12]
    end
  end

  // which codes rewrite the byte
  function modifies;
    input [3:0] c;
    begin
      modifies = (c == `CBMU_OP_SET_BIT) || (c == `CBMU_OP_CLEAR_BIT) ||
        (c == `CBMU_OP_INVERT_BIT) || (c == `CBMU_OP_STORE_CARRY) ||
        (c == `CBMU_OP_STORE_INVERTED_CARRY);
    end
  endfunction

  // the operand: latched register byte path or memory read data
  always @* begin
    mask = 8'h01 << bitno_r;
    is_modify = modifies(code_r);
    bit_val = |(operand & mask);
    case (code_r)
      `CBMU_OP_SET_BIT: mod_byte = operand | mask; // [RQ2]
      `CBMU_OP_CLEAR_BIT: mod_byte = operand & ~mask; // [RQ3]
      `CBMU_OP_INVERT_BIT: mod_byte = operand ^ mask; // [RQ4]
      `CBMU_OP_STORE_CARRY: begin
        mod_byte = carry_flag ? (operand | mask) : (operand & ~mask); // [RQ15]
      end
      `CBMU_OP_STORE_INVERTED_CARRY: begin
        mod_byte = carry_flag ? (operand & ~mask) : (operand | mask); // [RQ16]
      end
      default: mod_byte = operand;
    endcase
  end

  reg [7:0] reg_operand_r;
  reg mem_r;

  // memory data is whatever the bus returns; a write-only register
  // answering all ones is modified as all ones, not its true content
  always @* begin
    operand = mem_r ? bus_rdata : reg_operand_r; // [RQ19]
  end

  assign op_busy = (state_r != ST_IDLE);

  // sequencer: idle, read, write; a register operand takes one read cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      code_r <= 4'h0;
      bitno_r <= 3'h0;
      reg_operand_r <= 8'h00;
      mem_r <= 1'b0;
      op_done <= 1'b0;
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_addr <= {ADDR_W{1'b0}};
      bus_wdata <= 8'h00;
      carry_flag <= `CBMU_CARRY_RST;
      zero_flag <= `CBMU_ZERO_RST;
    end else begin
      op_done <= 1'b0;
      reg_we <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (op_start) begin
            code_r <= op_code;
            bitno_r <= sel_bitno;
            reg_operand_r <= op_reg_data;
            mem_r <= op_mem;
            bus_addr <= op_addr;
            bus_rd <= op_mem; // [RQ18] step one: read the byte
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (!mem_r || bus_rdy) begin
            bus_rd <= 1'b0;
            case (code_r)
              `CBMU_OP_TEST_BIT: zero_flag <= ~bit_val; // [RQ5]
              `CBMU_OP_AND_CARRY: carry_flag <= carry_flag & bit_val; // [RQ6]
              `CBMU_OP_AND_CARRY_INVERTED: carry_flag <= carry_flag & ~bit_val; // [RQ7]
              `CBMU_OP_OR_CARRY: carry_flag <= carry_flag | bit_val; // [RQ8]
              `CBMU_OP_OR_CARRY_INVERTED: carry_flag <= carry_flag | ~bit_val; // [RQ9]
              `CBMU_OP_XOR_CARRY: carry_flag <= carry_flag ^ bit_val; // [RQ10]
              `CBMU_OP_XOR_CARRY_INVERTED: carry_flag <= carry_flag ^ ~bit_val; // [RQ11]
              `CBMU_OP_LOAD_TO_CARRY: carry_flag <= bit_val; // [RQ13]
              `CBMU_OP_LOAD_INVERTED_TO_CARRY: carry_flag <= ~bit_val; // [RQ14]
              default: carry_flag <= carry_flag;
            endcase
            if (is_modify && mem_r) begin
              // whole byte goes back to the address just read
              bus_wr <= 1'b1; // [RQ17] [RQ18]
              bus_wdata <= mod_byte;
              state_r <= ST_WRITE;
            end else if (is_modify) begin
              reg_we <= 1'b1; // [RQ17]
              reg_wdata <= mod_byte;
              op_done <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              op_done <= 1'b1; // [RQ20] no write issued
              state_r <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (bus_rdy) begin
            bus_wr <= 1'b0; // [RQ18] step three done
            op_done <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          bus_rd <= 1'b0;
          bus_wr <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: bench/cbmu_bit_unit_assertions.sv
// checker: bus order and completion timing of the bit unit
// assumes a bind onto cbmu_bit_unit ports, one clock domain
`timescale 1ns/100ps
module cbmu_bit_unit_chk #(parameter ADDR_W = 16) (
  // clock, reset and request
  input logic mclk, rst_n, op_start, op_mem, op_busy, op_done, reg_we,
  input logic [3:0] op_code,
  // byte bus
  input logic bus_rd, bus_wr, bus_rdy,
  input logic [ADDR_W-1:0] bus_addr,
  input logic [7:0] bus_wdata, bus_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // request accepted only while idle
  wire take = op_start && !op_busy;
  rd_first_a: assert property (take && op_mem |=> bus_rd && !bus_wr)
    else $error("memory op did not open with a read");
  wr_same_addr_a: assert property ($rose(bus_wr) |-> $past(bus_rd && bus_rdy) && $stable(bus_addr))
    else $error("write not after read at same address");
  one_bit_a: assert property ($rose(bus_wr) |-> $countones(bus_wdata ^ $past(bus_rdata)) <= 1)
    else $error("write back alters more than one bit");
  ro_no_write_a: assert property (take && op_code inside {[3:11]} |=> (!bus_wr && !reg_we)[*2])
    else $error("read only op wrote its operand");
  rd_hold_a: assert property (bus_rd && !bus_rdy |=> bus_rd && $stable(bus_addr))
    else $error("read dropped before answer");
  wr_hold_a: assert property (bus_wr && !bus_rdy |=> bus_wr && $stable(bus_wdata))
    else $error("write dropped before answer");
  rw_excl_a: assert property (!(bus_rd && bus_wr))
    else $error("read and write together");
  reg_modify_a: assert property (take && !op_mem && !(op_code inside {[3:11]}) |-> ##2 reg_we && op_done)
    else $error("register byte not written back");
  wr_done_a: assert property (bus_wr && bus_rdy |=> op_done && !bus_wr)
    else $error("no completion after write");
  cover property (bus_wr && bus_rdy);
  cover property (reg_we);
  cover property (take && op_code == 4'h3);
endmodule

// file: bench/cbmu_bit_unit_tb.sv
// testbench: sweeps every op code over register and memory operands
// assumes cbmu_bit_unit and its checker are compiled first
`timescale 1ns/100ps
module cbmu_bit_unit_tb;
  logic mclk, rst_n, op_start, op_use_reg_bitno, op_mem, bus_rdy, c_exp, z_exp;
  logic op_busy, op_done, reg_we, bus_rd, bus_wr, carry_flag, zero_flag;
  logic [3:0] op_code;
  logic [2:0] op_imm_bitno;
  logic [7:0] op_reg_bitno, op_reg_data, bus_rdata, mem_b, wr_byte, reg_wdata, bus_wdata;
  logic [15:0] op_addr, bus_addr, wr_addr;
  int n_fail, compares, n_wr;
  cbmu_bit_unit dut_u (.mclk(mclk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code),
    .op_use_reg_bitno(op_use_reg_bitno), .op_imm_bitno(op_imm_bitno),
    .op_reg_bitno(op_reg_bitno), .op_mem(op_mem), .op_addr(op_addr),
    .op_reg_data(op_reg_data), .op_busy(op_busy), .op_done(op_done), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdy(bus_rdy),
    .carry_flag(carry_flag), .zero_flag(zero_flag));
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // bus slave: answers a cycle late; idle data inverted so stale reads show
  always @(posedge mclk) begin
    bus_rdy <= (bus_rd || bus_wr) && !bus_rdy;
    bus_rdata <= bus_rd ? mem_b : ~mem_b;
    if (bus_wr && bus_rdy) begin
      wr_byte <= bus_wdata;
      wr_addr <= bus_addr;
      n_wr <= n_wr + 1;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task run_op(input logic [3:0] c, input logic ur, input logic [2:0] ib,
              input logic [7:0] rb, input logic m, input logic [7:0] d);
    int t;
    mem_b = d;
    @(posedge mclk);
    op_start <= 1'h1;
    op_code <= c;
    op_use_reg_bitno <= ur;
    op_imm_bitno <= ib;
    op_reg_bitno <= rb;
    op_mem <= m;
    op_addr <= {8'h00, d};
    op_reg_data <= d;
    @(posedge mclk);
    op_start <= 1'h0;
    #1 chk({7'h00, op_busy}, 8'h01);
    t = 0;
    do begin
      @(posedge mclk);
      #1 t++;
    end while (op_done !== 1'h1 && t < 20);
    if (t >= 20) begin
      n_fail++;
      finish_test;
    end
  endtask
  task run_sweep;
    logic [3:0] c;
    logic [2:0] bn;
    logic [7:0] d, e;
    logic b, ur, m, modify;
    int w0;
    for (int k = 0; k < 56; k++) begin
      c = 4'(k % 14);
      ur = k >= 28;
      m = (k / 14) % 2;
      d = 8'h5A + 8'(k * 37);
      bn = (ur && !(c[0] && c > 4'h4)) ? 3'(k * 5) : 3'(k * 3);
      b = d[bn];
      e = d;
      modify = c < 4'h3 || c > 4'hB;
      case (c)
        4'h0: e[bn] = 1'h1;
        4'h1: e[bn] = 1'h0;
        4'h2: e[bn] = ~b;
        4'h3: z_exp = ~b;
        4'h4: c_exp = c_exp & b;
        4'h5: c_exp = c_exp & ~b;
        4'h6: c_exp = c_exp | b;
        4'h7: c_exp = c_exp | ~b;
        4'h8: c_exp = c_exp ^ b;
        4'h9: c_exp = c_exp ^ ~b;
        4'hA: c_exp = b;
        4'hB: c_exp = ~b;
        4'hC: e[bn] = c_exp;
        default: e[bn] = ~c_exp;
      endcase
      w0 = n_wr;
      run_op(c, ur, 3'(k * 3), {5'h15, 3'(k * 5)}, m, d);
      chk(8'(n_wr - w0), {7'h00, m && modify});
      chk({7'h00, reg_we}, {7'h00, !m && modify});
      if (modify) chk(m ? wr_byte : reg_wdata, e);
      if (m && modify) chk(wr_addr[7:0], d);
      if (m && modify) chk(wr_addr[15:8], 8'h00);
      chk({6'h00, carry_flag, zero_flag}, {6'h00, c_exp, z_exp});
    end
  endtask
  // write-only place reads back all ones; that is what gets modified
  task wo_clear;
    run_op(4'h1, 1'h0, 3'h0, 8'h00, 1'h1, 8'hFF);
    chk(wr_byte, 8'hFE);
  endtask
  initial begin
    {rst_n, op_start, op_use_reg_bitno, op_mem, bus_rdy, c_exp, z_exp} = 7'h00;
    {op_code, op_imm_bitno, op_reg_bitno, op_reg_data, bus_rdata, op_addr} = 47'h0;
    n_wr = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    run_sweep;
    wo_clear;
    finish_test;
  end
endmodule
bind cbmu_bit_unit cbmu_bit_unit_chk #(.ADDR_W(ADDR_W)) chk_u (.mclk(mclk), .rst_n(rst_n),
  .op_start(op_start), .op_mem(op_mem), .op_busy(op_busy), .op_done(op_done),
  .reg_we(reg_we), .op_code(op_code), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rdy(bus_rdy),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
